// ---- hw/iva_port.sv ----
// Purpose: indirect access port from serial registers into firmware variables
// Assumes: serial front end hands over decoded register strobes, one cycle each
// Notes: memory read data is taken at the end of the cycle in which mem_re_out stands
//
// Function
// [RL1] Register 0x098e holds the indirect address, 0x0990 carries its data.
// [RL2] A data write reaches memory only after the serial write cycle completes.
// [RL3] Updating the address register prefetches the addressed memory contents.
// [RL4] New settings apply only after refresh mode 6 then refresh 5.
// [RL5] Host should send refresh mode first, then refresh, back to back.
// [RL6] Address bit 15 chooses word access when 0, byte access when 1.
// [RL7] Address bits 14 to 10 select the firmware driver number.
// [RL8] Address bits 9 to 0 select the offset inside that driver.
// [RL9] Byte access moves only the low byte; reads show upper byte zero.
`default_nettype none
module iva_port #(
	parameter logic [14:0] SEQ_CMD_VAR = 15'h0000
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic wr_cycle_done_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic mem_we_out,
	output logic mem_re_out,
	output logic [14:0] mem_addr_out,
	output logic [15:0] mem_wdata_out,
	output logic [1:0] mem_be_out,
	input wire logic [15:0] mem_rdata_in,
	output logic refresh_mode_out,
	output logic refresh_out,
	output logic settings_pending_out
);
	iva_pkg::iva_regs_t cur_q;
	iva_pkg::iva_regs_t nxt_d;
	logic addr_wr;
	logic data_wr;
	logic commit;

	// the memory port carries exactly driver plus offset bits
	if (iva_pkg::MEM_AW != 15)
	begin
		$error("memory address width must be 15 bits");
	end

	// register decode strobes
	assign addr_wr = reg_wr_in && (reg_addr_in == iva_pkg::ADDR_REG_OFS); // [RL1]
	assign data_wr = reg_wr_in && (reg_addr_in == iva_pkg::DATA_REG_OFS); // [RL1]
	// commit only in idle so a fetch in flight is never torn
	assign commit = cur_q.pend && wr_cycle_done_in && (cur_q.st == iva_pkg::ST_IDLE); // [RL2]

	// next state of the whole block
	always_comb
	begin
		nxt_d = cur_q;
		nxt_d.mem_we = 1'b0;
		nxt_d.mem_re = 1'b0;
		nxt_d.rvalid = 1'b0;
		nxt_d.mode_pulse = 1'b0;
		nxt_d.apply_pulse = 1'b0;
		// host reads answer one cycle later; data register reads come from the prefetch buffer
		if (reg_rd_in)
		begin
			nxt_d.rvalid = 1'b1;
			if (reg_addr_in == iva_pkg::ADDR_REG_OFS)
				nxt_d.rdata = cur_q.addr;
			else if (reg_addr_in == iva_pkg::DATA_REG_OFS)
				nxt_d.rdata = cur_q.rdbuf; // [RL1]
			else
				nxt_d.rdata = 16'h0000;
		end
		// sequencer handshake and fetch engine
		case (cur_q.st)
			iva_pkg::ST_IDLE:
			begin
				if (commit)
				begin
					nxt_d.pend = 1'b0;
					nxt_d.mem_we = 1'b1; // [RL2]
					nxt_d.mem_addr = cur_q.waddr[iva_pkg::DRV_HI:iva_pkg::OFS_LO]; // [RL7] [RL8]
					if (cur_q.waddr[iva_pkg::WIDTH_BIT])
					begin
						nxt_d.mem_be = iva_pkg::BE_BYTE; // [RL6]
						nxt_d.mem_wdata = {8'h00, cur_q.wdata[7:0]}; // [RL9]
					end
					else
					begin
						nxt_d.mem_be = iva_pkg::BE_WORD; // [RL6]
						nxt_d.mem_wdata = cur_q.wdata;
					end
					nxt_d.st = iva_pkg::ST_REFETCH;
					// refresh needs mode command first, otherwise it is ignored
					if (cur_q.waddr[14:0] == SEQ_CMD_VAR)
					begin
						if (cur_q.wdata == iva_pkg::SEQ_REFRESH_MODE)
						begin
							nxt_d.armed = 1'b1; // [RL4]
							nxt_d.mode_pulse = 1'b1;
						end
						else if (cur_q.wdata == iva_pkg::SEQ_REFRESH && cur_q.armed)
						begin
							nxt_d.armed = 1'b0; // [RL4] [RL5]
							nxt_d.apply_pulse = 1'b1;
							nxt_d.dirty = 1'b0;
						end
					end
					else
						nxt_d.dirty = 1'b1;
				end
				else if (cur_q.fetch_req)
				begin
					nxt_d.fetch_req = 1'b0;
					nxt_d.mem_re = 1'b1; // [RL3]
					nxt_d.mem_addr = cur_q.addr[iva_pkg::DRV_HI:iva_pkg::OFS_LO]; // [RL7] [RL8]
					nxt_d.mem_be = cur_q.addr[iva_pkg::WIDTH_BIT] ? iva_pkg::BE_BYTE
						: iva_pkg::BE_WORD; // [RL6]
					nxt_d.st = iva_pkg::ST_WAIT;
				end
			end
			iva_pkg::ST_REFETCH:
			begin
				// reread so the data register shows the value just written
				nxt_d.fetch_req = 1'b1;
				nxt_d.st = iva_pkg::ST_IDLE;
			end
			iva_pkg::ST_WAIT:
			begin
				if (cur_q.mem_be == iva_pkg::BE_BYTE)
					nxt_d.rdbuf = {8'h00, mem_rdata_in[7:0]}; // [RL9]
				else
					nxt_d.rdbuf = mem_rdata_in; // [RL3]
				nxt_d.st = iva_pkg::ST_IDLE;
			end
			default:
				nxt_d.st = iva_pkg::ST_IDLE;
		endcase
		// host writes; a new address always wins over the fetch clear
		if (addr_wr)
		begin
			nxt_d.addr = reg_wdata_in; // [RL1]
			nxt_d.fetch_req = 1'b1; // [RL3]
		end
		// the write target is latched so a later address change cannot redirect it
		if (data_wr)
		begin
			nxt_d.wdata = reg_wdata_in;
			nxt_d.waddr = addr_wr ? reg_wdata_in : cur_q.addr;
			nxt_d.pend = 1'b1; // [RL2]
		end
	end

	// state register
	always_ff @(posedge clock_in)
	begin
		if (!nrst_in)
		begin
			cur_q <= '0;
			cur_q.st <= iva_pkg::ST_IDLE;
			cur_q.addr <= iva_pkg::ADDR_REG_RST;
			cur_q.wdata <= iva_pkg::DATA_REG_RST;
			cur_q.mem_be <= iva_pkg::BE_WORD;
		end
		else
			cur_q <= nxt_d;
	end

	// outputs straight from flops
	assign reg_rdata_out = cur_q.rdata;
	assign reg_rvalid_out = cur_q.rvalid;
	assign mem_we_out = cur_q.mem_we;
	assign mem_re_out = cur_q.mem_re;
	assign mem_addr_out = cur_q.mem_addr;
	assign mem_wdata_out = cur_q.mem_wdata;
	assign mem_be_out = cur_q.mem_be;
	assign refresh_mode_out = cur_q.mode_pulse;
	assign refresh_out = cur_q.apply_pulse;
	assign settings_pending_out = cur_q.dirty;

	// protocol checks, idle while reset is held
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	commit_after_done_a: assert property (commit |=> mem_we_out) // [RL2]
		else $error("write not committed after serial cycle end");
	no_early_write_a: assert property (mem_we_out |-> $past(wr_cycle_done_in)) // [RL2]
		else $error("memory written before serial cycle end");
	addr_prefetch_a: assert property (addr_wr && !data_wr |-> ##[1:8] mem_re_out) // [RL3]
		else $error("address update did not prefetch");
	data_read_a: assert property (reg_rd_in && reg_addr_in == iva_pkg::DATA_REG_OFS // [RL1]
		|=> reg_rvalid_out && reg_rdata_out == $past(cur_q.rdbuf))
		else $error("data read not from prefetch buffer");
	read_answer_a: assert property (reg_rvalid_out == $past(reg_rd_in)) // [RL1]
		else $error("read answer not one cycle after strobe");
	refresh_order_a: assert property (refresh_out |-> !cur_q.armed && $past(cur_q.armed)) // [RL4]
		else $error("refresh applied without refresh mode");
	mode_arms_a: assert property (refresh_mode_out |-> cur_q.armed) // [RL4]
		else $error("refresh mode did not arm refresh");
	refresh_clean_a: assert property (refresh_out |-> !settings_pending_out) // [RL4]
		else $error("settings still pending after refresh");
	byte_width_a: assert property (mem_we_out && $past(cur_q.waddr[15]) // [RL6]
		|-> mem_be_out == iva_pkg::BE_BYTE && mem_wdata_out[15:8] == 8'h00)
		else $error("byte access wrong lanes");
	word_width_a: assert property (mem_we_out && !$past(cur_q.waddr[15]) // [RL6]
		|-> mem_be_out == iva_pkg::BE_WORD && mem_wdata_out == $past(cur_q.wdata))
		else $error("word access wrong lanes or data");
	// the write target is the address latched with the data, not the live one
	write_target_a: assert property (commit // [RL8]
		|=> mem_addr_out == $past(cur_q.waddr[14:0]))
		else $error("write target not the latched address");
	drv_field_a: assert property (mem_re_out // [RL7]
		|-> mem_addr_out[14:10] == $past(cur_q.addr[14:10]))
		else $error("driver field not mapped");
	ofs_field_a: assert property (mem_re_out // [RL8]
		|-> mem_addr_out[9:0] == $past(cur_q.addr[9:0]))
		else $error("offset field not mapped");
	byte_read_a: assert property (cur_q.st == iva_pkg::ST_WAIT // [RL9]
		&& mem_be_out == iva_pkg::BE_BYTE |=> cur_q.rdbuf[15:8] == 8'h00)
		else $error("byte read upper byte not zero");
endmodule
`default_nettype wire

// ---- inc/iva_pkg.sv ----
// Purpose: shared constants and types for the indirect variable access port
// Assumes: 16-bit register words, byte-addressed microcontroller memory port
// Notes: driver and offset together form the memory byte address
`default_nettype none
package iva_pkg;
	// register decode on the serial register space
	localparam logic [15:0] ADDR_REG_OFS = 16'h098e;
	localparam logic [15:0] DATA_REG_OFS = 16'h0990;
	localparam logic [15:0] ADDR_REG_RST = 16'h0000;
	localparam logic [15:0] DATA_REG_RST = 16'h0000;
	// address register field layout
	localparam int WIDTH_BIT = 15;
	localparam int DRV_HI = 14;
	localparam int DRV_LO = 10;
	localparam int OFS_HI = 9;
	localparam int OFS_LO = 0;
	localparam int MEM_AW = DRV_HI + 1;
	// sequencer command values
	localparam logic [15:0] SEQ_REFRESH_MODE = 16'h0006;
	localparam logic [15:0] SEQ_REFRESH = 16'h0005;
	// byte enables for the two access widths
	localparam logic [1:0] BE_WORD = 2'h3;
	localparam logic [1:0] BE_BYTE = 2'h1;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REFETCH,
		ST_WAIT
	} iva_state_t;

	typedef struct packed {
		iva_state_t st;
		logic [15:0] addr;
		logic [15:0] waddr;
		logic [15:0] wdata;
		logic pend;
		logic fetch_req;
		logic [15:0] rdbuf;
		logic [15:0] rdata;
		logic rvalid;
		logic mem_we;
		logic mem_re;
		logic [MEM_AW-1:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [1:0] mem_be;
		logic armed;
		logic dirty;
		logic mode_pulse;
		logic apply_pulse;
	} iva_regs_t;
endpackage
`default_nettype wire

// ---- tb/indirect_variable_access_port_tb_top.sv ----
// Purpose: self-checking bench for the indirect access port
// Assumes: seq_cmd variable sits at driver 0 offset 0
// Notes: fixed gaps after writes let the prefetch land first
`default_nettype none
module indirect_variable_access_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic done = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata, mwdata, mrdata;
	logic [14:0] maddr;
	logic [1:0] be;
	logic rvalid, we, re, rmode, rfr, pend;
	int err_count = 0;
	int comparisons = 0;
	int nm = 0;
	int nr = 0;
	always #25 clk = ~clk;
	iva_port dut_u (.clock_in(clk), .nrst_in(nrst), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .wr_cycle_done_in(done),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .mem_we_out(we), .mem_re_out(re),
		.mem_addr_out(maddr), .mem_wdata_out(mwdata), .mem_be_out(be),
		.mem_rdata_in(mrdata), .refresh_mode_out(rmode), .refresh_out(rfr),
		.settings_pending_out(pend));
	iva_mem_model mem_u (.clock_in(clk), .we_in(we), .re_in(re), .addr_in(maddr),
		.wdata_in(mwdata), .be_in(be), .rdata_out(mrdata));
	// count command pulses so none slips between checks
	always @(posedge clk)
	begin
		if (rmode === 1'b1)
			nm++;
		if (rfr === 1'b1)
			nr++;
	end
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// every write closes its serial cycle with a stop pulse
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("read valid", 16'h0001, {15'h0000, rvalid});
		chk("read data", e, rdata);
	endtask
	task automatic word_path;
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		wr_reg(iva_pkg::DATA_REG_OFS, 16'hbeef);
		rd_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		rd_reg(iva_pkg::DATA_REG_OFS, 16'hbeef);
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0c12);
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		rd_reg(iva_pkg::DATA_REG_OFS, 16'hbeef);
		rd_reg(16'h0000, 16'h0000);
	endtask
	task automatic byte_path;
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h8c10);
		wr_reg(iva_pkg::DATA_REG_OFS, 16'h1234);
		rd_reg(iva_pkg::DATA_REG_OFS, 16'h0034);
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		rd_reg(iva_pkg::DATA_REG_OFS, 16'hbe34);
		chk("pending", 16'h0001, {15'h0000, pend});
	endtask
	// stray writes are ignored; a mid-run reset clears pending state
	task automatic reset_path;
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		wr_reg(iva_pkg::DATA_REG_OFS, 16'h5a5a);
		wr_reg(16'h0992, 16'hffff);
		rd_reg(iva_pkg::ADDR_REG_OFS, 16'h0c10);
		rd_reg(iva_pkg::DATA_REG_OFS, 16'h5a5a);
		chk("pending before reset", 16'h0001, {15'h0000, pend});
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		chk("pending after reset", 16'h0000, {15'h0000, pend});
		rd_reg(iva_pkg::ADDR_REG_OFS, iva_pkg::ADDR_REG_RST);
		rd_reg(iva_pkg::DATA_REG_OFS, iva_pkg::DATA_REG_RST);
	endtask
	// refresh alone is ignored; mode then refresh applies
	task automatic refresh_path;
		wr_reg(iva_pkg::ADDR_REG_OFS, 16'h0000);
		wr_reg(iva_pkg::DATA_REG_OFS, iva_pkg::SEQ_REFRESH);
		chk("lone refresh", 16'h0000, 16'(nr));
		wr_reg(iva_pkg::DATA_REG_OFS, iva_pkg::SEQ_REFRESH_MODE);
		wr_reg(iva_pkg::DATA_REG_OFS, iva_pkg::SEQ_REFRESH);
		chk("mode count", 16'h0001, 16'(nm));
		chk("refresh count", 16'h0001, 16'(nr));
		chk("pending", 16'h0000, {15'h0000, pend});
	endtask
	task automatic end_of_test;
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		word_path();
		byte_path();
		refresh_path();
		reset_path();
		end_of_test();
	end
	// whole run needs about 185 cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire

// ---- tb/iva_mem_model.sv ----
// Purpose: byte memory model behind the indirect port
// Assumes: read answered within the cycle in which the read strobe stands
// Notes: off-duty data lines invert so a stale value never passes
`default_nettype none
module iva_mem_model (
	input wire logic clock_in,
	input wire logic we_in,
	input wire logic re_in,
	input wire logic [14:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic [1:0] be_in,
	output logic [15:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] m [0:32767];
	logic [15:0] last_q = 16'h0000;
	// the port takes read data at the end of its strobe cycle
	assign rdata_out = re_in ? {m[addr_in + 15'h1], m[addr_in]} : ~last_q;
	// little-endian word, each lane only when enabled
	always @(posedge clock_in)
	begin
		if (we_in && be_in[0])
			m[addr_in] <= wdata_in[7:0];
		if (we_in && be_in[1])
			m[addr_in + 15'h1] <= wdata_in[15:8];
		if (re_in)
			last_q <= {m[addr_in + 15'h1], m[addr_in]};
	end
endmodule
`default_nettype wire
